// *** dv/pisr_mgmt.sv ***
// Management master model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pisr_mgmt (
    input  wire logic        core_clk,
    output var  logic [4:0]  reg_addr  = 5'h00,
    output var  logic [15:0] reg_wdata = 16'h0000,
    output var  logic        reg_wr    = 1'b0,
    output var  logic        reg_rd    = 1'b0,
    input  wire logic [15:0] reg_rdata
);
    // One-cycle write strobe beside address and data
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** dv/pisr_regs_props.sv ***
// Assertion checker for the status and control register bank
`timescale 1ns/1ps
`default_nettype none
module pisr_regs_props (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        remote_fault_seen,
    input wire logic        partner_negotiation_capable,
    input wire logic        negotiation_complete,
    input wire logic        speed_100,
    input wire logic        duplex_full,
    input wire logic        pause_on,
    input wire logic        receive_swing_select,
    input wire logic        remote_loopback_en,
    input wire logic        dc_restore_en,
    input wire logic        line_inversion_coding_en,
    input wire logic        block_code_en,
    input wire logic        error_counter_disable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Accesses actually taken, per register
    wire       rd_x  = clk_en && reg_rd && reg_addr == 5'h06;
    wire       rd_st = clk_en && reg_rd && reg_addr == 5'h11;
    wire       rd_ct = clk_en && reg_rd && reg_addr == 5'h13;
    wire       wr_ct = clk_en && reg_wr && reg_addr == 5'h13;
    wire       rd_un = clk_en && reg_rd && !(reg_addr inside {5'h06, 5'h11, 5'h12, 5'h13});
    // Writable control bits in register order, and the data that sets them
    wire [5:0] ctl    = {error_counter_disable, receive_swing_select, remote_loopback_en,
                         dc_restore_en, line_inversion_coding_en, block_code_en};
    wire [5:0] ctl_wd = {reg_wdata[13], reg_wdata[11], reg_wdata[9:6]};
    chk_unmapped_zero: assert property (rd_un |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_state_bits: assert property (rd_st |=>
        reg_rdata[15:7] == {6'h00, $past(speed_100), $past(duplex_full), $past(pause_on)})
        else $error("resolved state bits wrong");
    // Reset edge excluded: an event seen while in reset is not latched
    chk_fault_latch: assert property (rd_st && $past(remote_fault_seen) && !$past(rst)
        && $past(clk_en) |=> reg_rdata[5]) else $error("remote fault flag lost");
    chk_partner_cap: assert property (rd_x |=>
        reg_rdata[0] == $past(partner_negotiation_capable) && reg_rdata[15:2] == 14'h0000)
        else $error("expansion read wrong");
    chk_done_mirror: assert property (rd_ct |=>
        reg_rdata[12] == $past(negotiation_complete)) else $error("mirror bit wrong");
    chk_ctl_write: assert property (wr_ct |=> ctl == $past(ctl_wd))
        else $error("control outputs not written");
    chk_ctl_hold: assert property (!wr_ct |=> $stable(ctl))
        else $error("control outputs changed without write");
    chk_ctl_rdback: assert property (rd_ct |=> {reg_rdata[15:14], reg_rdata[10],
        reg_rdata[5:0]} == 9'h000 && {reg_rdata[13], reg_rdata[11], reg_rdata[9:6]} == $past(ctl))
        else $error("control read back wrong");
    cover property (rd_st ##1 reg_rdata[0]);
    cover property (rd_st ##1 reg_rdata[5]);
    cover property (wr_ct ##1 error_counter_disable);
endmodule
bind pisr_regs pisr_regs_props pisr_regs_props_i (.*);
`default_nettype wire

// *** dv/pisr_regs_test.sv ***
// Self-checking bench for the status and control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, ex) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module pisr_regs_test;
    logic        core_clk, rst, cap, irq_out, reg_wr, reg_rd, en;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [7:0]  ev;   // Rx error, six status sources, page received
    logic [2:0]  cfg;  // Speed, duplex, pause
    logic [5:0]  ctl;  // Counter off, swing, loopback, dc, nrzi, 4b5b
    int          err_count, comparisons;
    pisr_mgmt pisr_mgmt_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    pisr_regs pisr_regs_i (.core_clk(core_clk), .rst(rst), .clk_en(en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .page_received(ev[0]), .partner_negotiation_capable(cap), .negotiation_complete(ev[6]),
        .remote_fault_seen(ev[5]), .link_fail_event(ev[4]), .code_word_ack_received(ev[3]),
        .parallel_detect_fault(ev[2]), .negotiation_page_received(ev[1]), .rx_err_packet(ev[7]),
        .speed_100(cfg[2]), .duplex_full(cfg[1]), .pause_on(cfg[0]), .irq_out(irq_out),
        .receive_swing_select(ctl[4]), .remote_loopback_en(ctl[3]), .dc_restore_en(ctl[2]),
        .line_inversion_coding_en(ctl[1]), .block_code_en(ctl[0]), .error_counter_disable(ctl[5]));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Tests need about 480 cycles; this leaves a wide margin
    initial begin
        #300000;
        err_count++;
        complete_run();
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One-cycle event pulse, then quiet
    task automatic pulse(input logic [7:0] m);
        @(posedge core_clk) ev <= m;
        @(posedge core_clk) ev <= 8'h00;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] ex);
        pisr_mgmt_i.rd(a, d);
        `CHK("read data", d, ex)
    endtask
    // Flag lands one edge after the pulse, interrupt one edge later
    task automatic irq_is(input logic ex);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq_out", irq_out, ex)
    endtask
    initial begin
        rst = 1'b1;
        en = 1'b1;
        ev = 8'h00;
        cfg = 3'b111;
        cap = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        `CHK("reset outputs", ctl, 6'h07)
        rchk(5'h12, 16'h0000);
        rchk(5'h13, 16'h01c0);
        for (int i = 1; i < 7; i++) begin
            pulse(8'h01 << i);
            rchk(5'h11, 16'h0380 | (16'h0001 << i));
            rchk(5'h11, 16'h0380);
        end
        pulse(8'h01);
        rchk(5'h06, 16'h0003);
        rchk(5'h06, 16'h0001);
        pisr_mgmt_i.wr(5'h13, 16'hffff);
        rchk(5'h13, 16'h2bc0);
        `CHK("control outputs", ctl, 6'h3f)
        pisr_mgmt_i.wr(5'h12, 16'hffff);
        rchk(5'h12, 16'h007f);
        pisr_mgmt_i.wr(5'h12, 16'h0020);
        pulse(8'h10);
        irq_is(1'b0);
        pulse(8'h20);
        irq_is(1'b1);
        rchk(5'h11, 16'h03b0);
        irq_is(1'b0);
        pisr_mgmt_i.wr(5'h12, 16'h0001);
        // A write with the clock enable low must not land
        en <= 1'b0;
        pisr_mgmt_i.wr(5'h12, 16'h007f);
        en <= 1'b1;
        rchk(5'h12, 16'h0001);
        repeat (64) pulse(8'h80);
        rchk(5'h11, 16'h0380);
        pisr_mgmt_i.wr(5'h13, 16'h01c0);
        repeat (63) pulse(8'h80);
        rchk(5'h11, 16'h0380);
        pulse(8'h80);
        irq_is(1'b1);
        rchk(5'h11, 16'h0381);
        repeat (63) pulse(8'h80);
        rchk(5'h11, 16'h0380);
        pisr_mgmt_i.wr(5'h11, 16'hffff);
        pisr_mgmt_i.wr(5'h1f, 16'hffff);
        rchk(5'h11, 16'h0380);
        rchk(5'h1f, 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire

// *** rtl/pisr_defines.vh ***
// Register offsets, bit positions, reset values and counts for the status/control bank
`ifndef PISR_DEFINES_VH
`define PISR_DEFINES_VH

// Register indices on the management port (5-bit address)
`define PISR_ADDR_EXP        5'h06
`define PISR_ADDR_STATUS     5'h11
`define PISR_ADDR_ENABLE     5'h12
`define PISR_ADDR_FASTCTL    5'h13

// Expansion tail bit positions
`define PISR_EXP_PAGE_RX     1
`define PISR_EXP_PARTNER_AN  0

// Status register bit positions
`define PISR_ST_SPEED        9
`define PISR_ST_DUPLEX       8
`define PISR_ST_PAUSE        7
`define PISR_ST_EVENT_W      7

// Fast control bit positions
`define PISR_FC_CNT_DIS      13
`define PISR_FC_AN_DONE      12
`define PISR_FC_SWING        11
`define PISR_FC_RLOOP        9
`define PISR_FC_DCR          8
`define PISR_FC_NRZI         7
`define PISR_FC_4B5B         6

// Reset values
`define PISR_ENABLE_RST      7'h00
`define PISR_FASTCTL_RST     16'h01c0

// Receive errors counted before the full event
`define PISR_RXERR_FULL      64
`endif

// *** rtl/pisr_regs.v ***
// Status, interrupt enable and fast-line control registers of the transceiver
//
// Notes on behaviour
// (RULE1) Page-received bit latches, clears on read
// (RULE2) Expansion bit 0: partner negotiation capable
// (RULE3) Status bit 9 shows resolved speed
// (RULE4) Status bit 8 shows resolved duplex
// (RULE5) Status bit 7 shows pause enabled
// (RULE6) Bit 6 latches negotiation complete event
// (RULE7) Bit 5 latches remote fault event
// (RULE8) Bit 4 latches link fail event
// (RULE9) Bit 3 latches code word acknowledge
// (RULE10) Bit 2 latches parallel detect fault
// (RULE11) Bit 1 latches negotiation page received
// (RULE12) Bit 0 latches at 64 receive errors
// (RULE13) Enable bits 6..0 gate sources, reset 0
// (RULE14) Enable bit 0 gates error-full interrupt
// (RULE15) Control bit 13 stops error counter
// (RULE16) Control bit 12 mirrors negotiation complete
// (RULE17) Control bit 11 picks receive swing
// (RULE18) Control bit 9 enables remote loopback
// (RULE19) Control bit 8 enables DC restore
// (RULE20) Control bit 7 enables NRZI conversion
// (RULE21) Control bit 6 enables 4B/5B coding
// (RULE22) Interrupt while any enabled source set
// (RULE23) Read-only/reserved writes ignored, reserved read zero
// (RULE24) Count errored packets, restart after full
//
// The plain strobed port is this design's own decision.
`include "pisr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pisr_regs #(
    parameter integer CNT_W = 7   // Error counter width, must hold the full count
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        clk_en,
    // Register port
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Event pulses from the negotiation and receive logic
    input  wire        page_received,
    input  wire        partner_negotiation_capable,
    input  wire        negotiation_complete,
    input  wire        remote_fault_seen,
    input  wire        link_fail_event,
    input  wire        code_word_ack_received,
    input  wire        parallel_detect_fault,
    input  wire        negotiation_page_received,
    input  wire        rx_err_packet,
    // Resolved operating state
    input  wire        speed_100,
    input  wire        duplex_full,
    input  wire        pause_on,
    // Interrupt and line controls
    output reg         irq_out,
    output reg         receive_swing_select,
    output reg         remote_loopback_en,
    output reg         dc_restore_en,
    output reg         line_inversion_coding_en,
    output reg         block_code_en,
    output reg         error_counter_disable
);

    // Latched page-received flag of the expansion register
    reg              page_rx_r;
    // Latched event sources, bit order as in status register
    reg  [6:0]       event_r;
    // Interrupt enables
    reg  [6:0]       event_enable_r;
    // Receive error counter
    reg  [CNT_W-1:0] err_cnt_r;
    reg  [CNT_W-1:0] err_cnt_nxt;
    reg              err_full;
    // Incoming events, same order as event_r
    wire [6:0]       event_in;
    // Read strobes per register
    wire             rd_exp;
    wire             rd_status;
    // Read data candidate
    reg  [15:0]      rdata_nxt;

    // Register select decode shared by reads and writes
    function sel;
        input [4:0] addr;
        input [4:0] target;
        begin
            sel = (addr == target);
        end
    endfunction

    assign rd_exp    = reg_rd & sel(reg_addr, `PISR_ADDR_EXP);
    assign rd_status = reg_rd & sel(reg_addr, `PISR_ADDR_STATUS);

    // Error counter next state
    always @* begin
        err_cnt_nxt = err_cnt_r;
        err_full    = 1'b0;
        // (RULE15) counter halted
        if (rx_err_packet && !error_counter_disable) begin
            // (RULE24) count and restart
            if (err_cnt_r == (`PISR_RXERR_FULL - 1)) begin
                err_cnt_nxt = {CNT_W{1'b0}};
                err_full    = 1'b1;
            end else begin
                err_cnt_nxt = err_cnt_r + 1'b1;
            end
        end
    end

    // (RULE6) (RULE7) (RULE8) source order
    // (RULE9) (RULE10) (RULE11) (RULE12) source order
    assign event_in = {negotiation_complete, remote_fault_seen, link_fail_event,
                       code_word_ack_received, parallel_detect_fault,
                       negotiation_page_received, err_full};

    // Latched flags: a new event in the read cycle wins over the clear
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            page_rx_r <= 1'b0;
            event_r   <= 7'h00;
            err_cnt_r <= {CNT_W{1'b0}};
        end else if (clk_en) begin
            err_cnt_r <= err_cnt_nxt;
            // (RULE1) latch, clear on read
            page_rx_r <= page_received | (page_rx_r & ~rd_exp);
            // (RULE12) latch then read-clear
            event_r   <= event_in | (event_r & {7{~rd_status}});
        end
    end

    // Writable registers; read-only bits never loaded
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // (RULE13) enables reset off
            event_enable_r           <= `PISR_ENABLE_RST;
            // (RULE15) counter runs after reset
            error_counter_disable    <= 1'b0;
            receive_swing_select     <= 1'b0;
            remote_loopback_en       <= 1'b0;
            dc_restore_en            <= 1'b1;
            line_inversion_coding_en <= 1'b1;
            block_code_en            <= 1'b1;
        end else if (clk_en && reg_wr) begin
            // (RULE23) only writable bits kept
            if (sel(reg_addr, `PISR_ADDR_ENABLE)) begin
                // (RULE13) store enables
                event_enable_r <= reg_wdata[6:0];
            end
            if (sel(reg_addr, `PISR_ADDR_FASTCTL)) begin
                // (RULE15) counter stop bit
                error_counter_disable    <= reg_wdata[`PISR_FC_CNT_DIS];
                // (RULE17) swing select
                receive_swing_select     <= reg_wdata[`PISR_FC_SWING];
                // (RULE18) remote loopback
                remote_loopback_en       <= reg_wdata[`PISR_FC_RLOOP];
                // (RULE19) DC restore
                dc_restore_en            <= reg_wdata[`PISR_FC_DCR];
                // (RULE20) NRZI conversion
                line_inversion_coding_en <= reg_wdata[`PISR_FC_NRZI];
                // (RULE21) block coding
                block_code_en            <= reg_wdata[`PISR_FC_4B5B];
            end
        end
    end

    // Read data mux; unmapped addresses read zero
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `PISR_ADDR_EXP: begin
                // (RULE1) page flag
                rdata_nxt[`PISR_EXP_PAGE_RX]    = page_rx_r;
                // (RULE2) partner capability
                rdata_nxt[`PISR_EXP_PARTNER_AN] = partner_negotiation_capable;
            end
            `PISR_ADDR_STATUS: begin
                // (RULE3) speed
                rdata_nxt[`PISR_ST_SPEED]  = speed_100;
                // (RULE4) duplex
                rdata_nxt[`PISR_ST_DUPLEX] = duplex_full;
                // (RULE5) pause
                rdata_nxt[`PISR_ST_PAUSE]  = pause_on;
                rdata_nxt[6:0]             = event_r;
            end
            `PISR_ADDR_ENABLE: begin
                // (RULE23) reserved zero
                rdata_nxt[6:0] = event_enable_r;
            end
            `PISR_ADDR_FASTCTL: begin
                rdata_nxt[`PISR_FC_CNT_DIS] = error_counter_disable;
                // (RULE16) mirror of completion level
                rdata_nxt[`PISR_FC_AN_DONE] = negotiation_complete;
                rdata_nxt[`PISR_FC_SWING]   = receive_swing_select;
                rdata_nxt[`PISR_FC_RLOOP]   = remote_loopback_en;
                rdata_nxt[`PISR_FC_DCR]     = dc_restore_en;
                rdata_nxt[`PISR_FC_NRZI]    = line_inversion_coding_en;
                rdata_nxt[`PISR_FC_4B5B]    = block_code_en;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    // Read data registered, valid only the cycle after the strobe
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            irq_out   <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
            // (RULE22) (RULE14) gated interrupt
            irq_out   <= |(event_r & event_enable_r);
        end
    end

endmodule
`default_nettype wire
